// file: common/pdb_pkg.sv
// pdb_pkg: register map, field layout, codes and states of the dead-band
// and output logic block.
// assumes a 32-bit APB master; each register sits in one aligned word.
package pdb_pkg;

    localparam int unsigned ADDR_W = 18;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_W = 16;
    localparam int unsigned NUM_UNITS = 3;
    localparam int unsigned NUM_PINS = 9;
    localparam int unsigned NUM_FULL_PINS = 6;
    localparam int unsigned PERIOD_W = 8;
    localparam int unsigned PSC_CNT_W = 3;

    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_COMPARE_CONTROL = 16'h7411;
    localparam logic [15:0] IDX_FULL_ACTION = 16'h7413;
    localparam logic [15:0] IDX_SIMPLE_ACTION = 16'h7414;
    localparam logic [15:0] IDX_DEAD_BAND_CONTROL = 16'h7415;
    localparam logic [15:0] IDX_STATUS = 16'h7416;

    // dead_band_control fields
    localparam int unsigned DB_PERIOD_LSB = 8;
    localparam int unsigned DB_EN_UNIT1 = 5;
    localparam int unsigned DB_PSC_LSB = 3;
    localparam logic [15:0] DB_CTRL_MASK = 16'hFFF8;
    localparam logic [15:0] DB_CTRL_RESET = 16'h0000;

    // compare_control_reg fields
    localparam int unsigned CC_FULL_OE = 9;
    localparam int unsigned CC_SIMPLE_OE = 8;
    localparam int unsigned CC_PROTECT_EN = 3;
    localparam int unsigned CC_MODE_LSB = 0;
    localparam logic [15:0] CC_MASK = 16'h030F;
    localparam logic [15:0] CC_RESET = 16'h0000;

    localparam logic [15:0] FULL_ACT_MASK = 16'h0FFF;
    localparam logic [15:0] SIMPLE_ACT_MASK = 16'h003F;
    localparam logic [15:0] ACT_RESET = 16'h0000;

    // status fields
    localparam int unsigned ST_TRUE_LSB = 9;
    localparam int unsigned ST_COMP_LSB = 12;
    localparam int unsigned ST_PROTECT = 15;

    // prescaler: last count of each divide ratio (divisor minus one)
    localparam logic [1:0] PSC_DIV1 = 2'h0;
    localparam logic [1:0] PSC_DIV2 = 2'h1;
    localparam logic [1:0] PSC_DIV4 = 2'h2;
    localparam logic [1:0] PSC_DIV8 = 2'h3;
    localparam logic [2:0] PSC_LAST_DIV1 = 3'h0;
    localparam logic [2:0] PSC_LAST_DIV2 = 3'h1;
    localparam logic [2:0] PSC_LAST_DIV4 = 3'h3;
    localparam logic [2:0] PSC_LAST_DIV8 = 3'h7;

    // action codes, PWM reading and compare reading
    localparam logic [1:0] PWM_FORCED_LOW = 2'h0;
    localparam logic [1:0] PWM_ACTIVE_LOW = 2'h1;
    localparam logic [1:0] PWM_ACTIVE_HIGH = 2'h2;
    localparam logic [1:0] PWM_FORCED_HIGH = 2'h3;
    localparam logic [1:0] CMP_HOLD = 2'h0;
    localparam logic [1:0] CMP_RESET = 2'h1;
    localparam logic [1:0] CMP_SET = 2'h2;
    localparam logic [1:0] CMP_TOGGLE = 2'h3;

    typedef enum logic [2:0] {
        DB_FOLLOW = 3'b001,
        DB_WAIT = 3'b010,
        DB_SETTLED = 3'b100
    } pdb_db_state_t;

endpackage

// file: hdl/pdb_output_logic.sv
// pdb_output_logic: dead-band insertion for three full compare units and
// output logic with polarity, compare actions and tri-state for nine pins.
// assumes all inputs synchronous to clk; APB slave with one access cycle.
//
// Summary of operation
// [R1] one 8-bit period in control bits 15..8 serves all three timers
// [R2] bits 7, 6, 5 enable dead-band for units 3, 2, 1
// [R3] bits 4..3 prescale timers from CPU clock: 1, 2, 4 or 8
// [R4] control bits 2..0 read zero and ignore writes
// [R5] every control field resets to zero
// [R6] three waveform inputs, one per full compare unit
// [R7] dead-band off: both outputs of a pair equal the input
// [R8] dead-band on: pair edges separated by prescale times period clocks
// [R9] with dead-band on, on periods of upper and lower outputs never overlap
// [R10] with dead-band on, outputs are not forced inactive at period end
// [R11] compare mode bypasses dead-band whatever the enable bit
// [R12] PWM mode: active low, active high, forced low or forced high
// [R13] compare mode: hold, set, reset or toggle on a compare match
// [R14] output enables, unmasked protect low or reset tri-state the pins
// [R15] protect and reset override enables and action settings
// [R16] output logic merges dead-band, matches, simple waves, action bits
// [R17] action code 00..11: hold/reset/set/toggle or low/alow/ahigh/high
// [R18] three 8-bit down-counting timers run from the CPU clock
// [R19] each input edge reloads the timer; new rising edge waits for zero
// [R20] period zero inserts no delay
// [R21] pulse shorter than dead-band leaves both outputs inactive
//
// Local design decision: the APB slave port.
module pdb_output_logic
    import pdb_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic phaseWaveIn1,
    input wire logic phaseWaveIn2,
    input wire logic phaseWaveIn3,
    input wire logic [NUM_UNITS-1:0] fullCompareMatch,
    input wire logic [NUM_UNITS-1:0] simpleWaveIn,
    input wire logic powerDriveProtect_b,
    output logic [NUM_PINS-1:0] comparePwmPin,
    output logic [NUM_PINS-1:0] comparePwmPinOe_b
);

    function automatic logic [2:0] pscLast(input logic [1:0] code);
        logic [2:0] last;
        last = PSC_LAST_DIV1;
        unique case (code)
            PSC_DIV1: last = PSC_LAST_DIV1;
            PSC_DIV2: last = PSC_LAST_DIV2;
            PSC_DIV4: last = PSC_LAST_DIV4;
            PSC_DIV8: last = PSC_LAST_DIV8;
        endcase
        return last;
    endfunction

    function automatic logic pwmLevel(input logic [1:0] act,
                                      input logic src);
        logic lvl;
        lvl = 1'b0;
        unique case (act)
            PWM_FORCED_LOW: lvl = 1'b0;
            PWM_ACTIVE_LOW: lvl = ~src;
            PWM_ACTIVE_HIGH: lvl = src;
            PWM_FORCED_HIGH: lvl = 1'b1;
        endcase
        return lvl;
    endfunction

    function automatic logic cmpLevel(input logic [1:0] act,
                                      input logic cur,
                                      input logic hit);
        logic lvl;
        lvl = cur;
        if (hit) begin
            unique case (act)
                CMP_HOLD: lvl = cur;
                CMP_RESET: lvl = 1'b0;
                CMP_SET: lvl = 1'b1;
                CMP_TOGGLE: lvl = ~cur;
            endcase
        end
        return lvl;
    endfunction

    function automatic logic [ADDR_W-1:0] byteAddr(input logic [15:0] idx);
        return {idx, 2'b00};
    endfunction

    logic [REG_W-1:0] deadBandControl_reg;
    logic [REG_W-1:0] compareControl_reg;
    logic [REG_W-1:0] fullCompareAction_reg;
    logic [REG_W-1:0] simpleCompareAction_reg;

    logic [PERIOD_W-1:0] dbPeriod;
    logic [NUM_UNITS-1:0] dbEnable;
    logic [1:0] dbPrescale;
    logic [NUM_UNITS-1:0] cmpMode;
    logic [NUM_UNITS-1:0] dbBypass;
    logic [NUM_UNITS-1:0] waveIn;
    logic protectTrip;

    assign dbPeriod = deadBandControl_reg[DB_PERIOD_LSB +: PERIOD_W]; // R1
    assign dbEnable = deadBandControl_reg[DB_EN_UNIT1 +: NUM_UNITS]; // R2
    assign dbPrescale = deadBandControl_reg[DB_PSC_LSB +: 2]; // R3
    assign cmpMode = compareControl_reg[CC_MODE_LSB +: NUM_UNITS];
    assign dbBypass = ~dbEnable | cmpMode; // R11
    assign waveIn = {phaseWaveIn3, phaseWaveIn2, phaseWaveIn1}; // R6
    assign protectTrip = compareControl_reg[CC_PROTECT_EN]
                         & ~powerDriveProtect_b;

    // APB decode; no wait states, unmapped addresses answer pslverr
    logic setupPhase;
    logic accessWrite;
    logic addrHit;
    logic [REG_W-1:0] readMux;
    logic [REG_W-1:0] statusWord;

    assign setupPhase = psel & ~penable;
    assign accessWrite = psel & penable & pready & pwrite;

    always_comb begin
        addrHit = 1'b1;
        readMux = '0;
        unique case (paddr)
            byteAddr(IDX_COMPARE_CONTROL): readMux = compareControl_reg;
            byteAddr(IDX_FULL_ACTION): readMux = fullCompareAction_reg;
            byteAddr(IDX_SIMPLE_ACTION): readMux = simpleCompareAction_reg;
            byteAddr(IDX_DEAD_BAND_CONTROL): readMux = deadBandControl_reg;
            byteAddr(IDX_STATUS): readMux = statusWord;
            default: addrHit = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else if (ce) begin
            pready <= setupPhase;
            pslverr <= setupPhase & ~addrHit;
            if (setupPhase) begin
                prdata <= {{(DATA_W-REG_W){1'b0}}, readMux};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            deadBandControl_reg <= DB_CTRL_RESET; // R5
            compareControl_reg <= CC_RESET;
            fullCompareAction_reg <= ACT_RESET;
            simpleCompareAction_reg <= ACT_RESET;
        end else if (ce && accessWrite && !pslverr) begin
            unique case (paddr)
                byteAddr(IDX_COMPARE_CONTROL):
                    compareControl_reg <= pwdata[REG_W-1:0] & CC_MASK;
                byteAddr(IDX_FULL_ACTION):
                    fullCompareAction_reg <= pwdata[REG_W-1:0]
                                             & FULL_ACT_MASK;
                byteAddr(IDX_SIMPLE_ACTION):
                    simpleCompareAction_reg <= pwdata[REG_W-1:0]
                                               & SIMPLE_ACT_MASK;
                byteAddr(IDX_DEAD_BAND_CONTROL):
                    deadBandControl_reg <= pwdata[REG_W-1:0]
                                           & DB_CTRL_MASK; // R4
                default: ;
            endcase
        end
    end

    // dead-band unit: one 8-bit down counter and prescale count per unit
    logic [NUM_UNITS-1:0] waveQ_reg;
    logic [NUM_UNITS-1:0] dbTrue_reg;
    logic [NUM_UNITS-1:0] dbComp_reg;
    logic [PERIOD_W-1:0] dbTimer_reg [NUM_UNITS];
    logic [PSC_CNT_W-1:0] dbPsc_reg [NUM_UNITS];
    pdb_db_state_t dbState_reg [NUM_UNITS];
    logic [2:0] pscEnd;

    assign pscEnd = pscLast(dbPrescale);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            waveQ_reg <= '0;
            dbTrue_reg <= '0;
            dbComp_reg <= '0;
            for (int u = 0; u < NUM_UNITS; u++) begin
                dbTimer_reg[u] <= '0;
                dbPsc_reg[u] <= '0;
                dbState_reg[u] <= DB_FOLLOW;
            end
        end else if (ce) begin
            waveQ_reg <= waveIn;
            for (int u = 0; u < NUM_UNITS; u++) begin
                if (dbBypass[u]) begin
                    dbTrue_reg[u] <= waveIn[u]; // R7
                    dbComp_reg[u] <= waveIn[u]; // R7
                    dbTimer_reg[u] <= '0;
                    dbPsc_reg[u] <= '0;
                    dbState_reg[u] <= DB_FOLLOW;
                end else if (waveIn[u] != waveQ_reg[u]
                             || dbState_reg[u] == DB_FOLLOW) begin
                    // turning on dead-band also starts a gap, so the
                    // pair cannot overlap right after the enable
                    if (dbPeriod == '0) begin
                        dbTrue_reg[u] <= waveIn[u]; // R20
                        dbComp_reg[u] <= ~waveIn[u]; // R20
                        dbState_reg[u] <= DB_SETTLED;
                    end else begin
                        dbTrue_reg[u] <= 1'b0; // R9
                        dbComp_reg[u] <= 1'b0; // R21
                        dbTimer_reg[u] <= dbPeriod; // R19
                        dbPsc_reg[u] <= '0;
                        dbState_reg[u] <= DB_WAIT;
                    end
                end else begin
                    unique case (dbState_reg[u])
                        DB_WAIT: begin
                            if (dbPsc_reg[u] == pscEnd) begin // R3
                                dbPsc_reg[u] <= '0;
                                if (dbTimer_reg[u] == PERIOD_W'(1)) begin
                                    dbTimer_reg[u] <= '0;
                                    dbTrue_reg[u] <= waveIn[u]; // R8
                                    dbComp_reg[u] <= ~waveIn[u]; // R8
                                    dbState_reg[u] <= DB_SETTLED;
                                end else begin
                                    dbTimer_reg[u] <= dbTimer_reg[u]
                                                      - PERIOD_W'(1); // R18
                                end
                            end else begin
                                dbPsc_reg[u] <= dbPsc_reg[u]
                                                + PSC_CNT_W'(1);
                            end
                        end
                        // settled pair holds until the next input edge
                        DB_SETTLED: dbState_reg[u] <= DB_SETTLED; // R10
                        DB_FOLLOW: dbState_reg[u] <= DB_FOLLOW;
                    endcase
                end
            end
        end
    end

    // output logic
    logic [NUM_FULL_PINS-1:0] cmpState_reg;
    logic [NUM_FULL_PINS-1:0] cmpNext;
    logic [NUM_PINS-1:0] levelNext;
    logic [NUM_PINS-1:0] oeNext_b;

    always_comb begin
        cmpNext = cmpState_reg;
        levelNext = '0;
        for (int y = 0; y < NUM_FULL_PINS; y++) begin
            cmpNext[y] = cmpLevel(fullCompareAction_reg[2*y +: 2],
                                  cmpState_reg[y],
                                  fullCompareMatch[y/2]); // R13
            if (cmpMode[y/2]) begin
                levelNext[y] = cmpNext[y]; // R17
            end else if (y % 2 == 0) begin
                levelNext[y] = pwmLevel(fullCompareAction_reg[2*y +: 2],
                                        dbTrue_reg[y/2]); // R12
            end else begin
                levelNext[y] = pwmLevel(fullCompareAction_reg[2*y +: 2],
                                        dbComp_reg[y/2]); // R12
            end
        end
        for (int s = 0; s < NUM_UNITS; s++) begin
            levelNext[NUM_FULL_PINS+s] =
                pwmLevel(simpleCompareAction_reg[2*s +: 2],
                         simpleWaveIn[s]); // R16
        end
    end

    always_comb begin
        oeNext_b = '1;
        if (!protectTrip) begin // R15
            oeNext_b[NUM_FULL_PINS-1:0] =
                {NUM_FULL_PINS{~compareControl_reg[CC_FULL_OE]}}; // R14
            oeNext_b[NUM_PINS-1:NUM_FULL_PINS] =
                {NUM_UNITS{~compareControl_reg[CC_SIMPLE_OE]}}; // R14
        end
    end

    assign statusWord = {protectTrip, dbComp_reg, dbTrue_reg, comparePwmPin};

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cmpState_reg <= '0;
            comparePwmPin <= '0;
            comparePwmPinOe_b <= '1; // R14
        end else if (ce) begin
            cmpState_reg <= cmpNext;
            comparePwmPin <= levelNext;
            comparePwmPinOe_b <= oeNext_b;
        end
    end

endmodule // pdb_output_logic

// file: tb/pdb_output_logic_properties.sv
// pdb_output_logic_properties: port-level checks of the dead-band block.
// assumes ce held high; register state is shadowed from accepted writes.
module pdb_output_logic_properties
    import pdb_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic powerDriveProtect_b,
    input wire logic [NUM_PINS-1:0] comparePwmPin,
    input wire logic [NUM_PINS-1:0] comparePwmPinOe_b
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] ccReg, actReg, sactReg, dbReg;
    logic wrDone, mapped, dbPair, lowOne, highSev;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    assign wrDone = psel && penable && pready && pwrite && !pslverr;
    assign mapped = paddr inside {{IDX_COMPARE_CONTROL, 2'b00},
        {IDX_FULL_ACTION, 2'b00}, {IDX_SIMPLE_ACTION, 2'b00},
        {IDX_DEAD_BAND_CONTROL, 2'b00}, {IDX_STATUS, 2'b00}};
    assign dbPair = !ccReg[0] && dbReg[DB_EN_UNIT1] && actReg[3:0] == 4'hA;
    assign lowOne = !ccReg[0] && actReg[1:0] == PWM_FORCED_LOW;
    assign highSev = sactReg[1:0] == PWM_FORCED_HIGH;
    // refused writes must not move the shadows, or checks drift
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ccReg <= 16'h0000;
            actReg <= 16'h0000;
            sactReg <= 16'h0000;
            dbReg <= 16'h0000;
        end else if (wrDone) begin
            if (paddr == {IDX_COMPARE_CONTROL, 2'b00}) ccReg <= pwdata[15:0];
            if (paddr == {IDX_FULL_ACTION, 2'b00}) actReg <= pwdata[15:0];
            if (paddr == {IDX_SIMPLE_ACTION, 2'b00}) sactReg <= pwdata[15:0];
            if (paddr == {IDX_DEAD_BAND_CONTROL, 2'b00}) dbReg <= pwdata[15:0];
        end
    end
    chk_ready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("pready is not a one-cycle answer");
    chk_reset_tristate: assert property (disable iff (1'b0)
        !rst_b |=> &comparePwmPinOe_b && comparePwmPin == 9'h000)
        else $error("reset leaves pins driven");
    chk_protect_trip: assert property (
        ccReg[CC_PROTECT_EN] && !powerDriveProtect_b |=> &comparePwmPinOe_b)
        else $error("protect did not tri-state pins");
    chk_full_oe_off: assert property (
        !ccReg[CC_FULL_OE] && !$past(ccReg[CC_FULL_OE])
        |-> &comparePwmPinOe_b[5:0]) else $error("full pins driven");
    chk_simple_oe_off: assert property (
        !ccReg[CC_SIMPLE_OE] && !$past(ccReg[CC_SIMPLE_OE])
        |-> &comparePwmPinOe_b[8:6]) else $error("simple pins driven");
    chk_pair_overlap: assert property (
        dbPair && $past(dbPair) && $past(dbPair, 2)
        |-> !(comparePwmPin[0] && comparePwmPin[1]))
        else $error("pair one outputs overlap");
    chk_forced_low: assert property (lowOne && $past(lowOne)
        |-> !comparePwmPin[0]) else $error("forced low pin one high");
    chk_forced_high: assert property (highSev && $past(highSev)
        |-> comparePwmPin[6]) else $error("forced high pin seven low");
    chk_addr_decode: assert property (pready |-> pslverr == !mapped)
        else $error("slave error does not match decode");
    chk_reserved_read: assert property (
        pready && !pwrite && paddr == {IDX_DEAD_BAND_CONTROL, 2'b00}
        |-> prdata[2:0] == 3'h0 && prdata[31:16] == 16'h0000)
        else $error("reserved bits read non-zero");
endmodule // pdb_output_logic_properties

bind pdb_output_logic pdb_output_logic_properties
    pdb_output_logic_properties_i (.clk(clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .powerDriveProtect_b(powerDriveProtect_b), .comparePwmPin(comparePwmPin),
    .comparePwmPinOe_b(comparePwmPinOe_b));

// file: tb/pdb_gate_driver_model.sv
// pdb_gate_driver_model: gate drivers of three inverter legs, pins 1..6.
// assumes upper gate on odd pin, lower on even; a released pin is pulled
// low by its gate resistor, so a tri-stated leg turns both devices off.
module pdb_gate_driver_model
    import pdb_pkg::*;
(
    input wire logic clk,
    input wire logic [NUM_PINS-1:0] pin,
    input wire logic [NUM_PINS-1:0] pinOe_b,
    output logic [NUM_FULL_PINS-1:0] gateOn,
    output int shoots
);
    timeunit 1ns;
    timeprecision 1ns;
    int shootCnt = 0;
    assign gateOn = pin[5:0] & ~pinOe_b[5:0];
    assign shoots = shootCnt;
    // both devices of one leg on together would short the supply
    always @(posedge clk) begin
        shootCnt <= shootCnt
                    + int'(|(gateOn[4:0] & gateOn[5:1] & 5'h15));
    end
endmodule // pdb_gate_driver_model

// file: tb/test_pdb_output_logic.sv
// test_pdb_output_logic: directed scenarios for the dead-band block.
// assumes ce held high; all inputs change by NBA after rising edges.
module test_pdb_output_logic
    import pdb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, ph1 = 1'b0, ph2 = 1'b0, ph3 = 1'b0;
    logic protect_b = 1'b1, pready, pslverr, err;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0, prdata;
    logic [2:0] match = 3'h0, simple = 3'h0;
    logic [NUM_PINS-1:0] pin, pinOe_b;
    logic [NUM_FULL_PINS-1:0] gateOn;
    logic [15:0] rd;
    int fails = 0, n_compared = 0, shoots;
    always #10 clk = ~clk;
    pdb_output_logic pdb_output_logic_i (.clk(clk), .rst_b(rst_b), .ce(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .phaseWaveIn1(ph1), .phaseWaveIn2(ph2), .phaseWaveIn3(ph3),
        .fullCompareMatch(match), .simpleWaveIn(simple),
        .powerDriveProtect_b(protect_b), .comparePwmPin(pin),
        .comparePwmPinOe_b(pinOe_b));
    pdb_gate_driver_model pdb_gate_driver_model_i (.clk(clk), .pin(pin),
        .pinOe_b(pinOe_b), .gateOn(gateOn), .shoots(shoots));
    task automatic tally_and_finish();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [15:0] idx,
                       input logic [15:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {16'h0000, wd};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            fails++;
            tally_and_finish();
        end
        rd = prdata[15:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // edge separation: cycles from the falling pin to the rising one
    task automatic gap(input int up, input int exp);
        int n, a, b;
        n = 0;
        a = -1;
        b = -1;
        while (b < 0 && n < 200) begin
            @(posedge clk);
            if (a < 0 && pin[1-up] === 1'b0) a = n;
            if (b < 0 && pin[up] === 1'b1) b = n;
            n++;
        end
        if (b < 0) begin
            fails++;
            tally_and_finish();
        end
        chk(b - a, exp);
    endtask
    task automatic regs();
        apb(1'b0, IDX_DEAD_BAND_CONTROL, 16'h0000);
        chk(rd, DB_CTRL_RESET);
        chk(pinOe_b, 9'h1FF);
        apb(1'b1, IDX_DEAD_BAND_CONTROL, 16'hFFFF);
        apb(1'b0, IDX_DEAD_BAND_CONTROL, 16'h0000);
        chk(rd, 16'hFFF8);
        apb(1'b1, IDX_DEAD_BAND_CONTROL, 16'h0000);
        apb(1'b0, 16'h7412, 16'h0000);
        chk(err, 1'b1);
        apb(1'b1, IDX_COMPARE_CONTROL, 16'h0300);
        apb(1'b1, IDX_FULL_ACTION, 16'h0AAA);
    endtask
    task automatic db_timing(input logic [7:0] m, input logic [1:0] ps);
        apb(1'b1, IDX_DEAD_BAND_CONTROL, {m, 3'b111, ps, 3'b000});
        repeat (70) @(posedge clk);
        {ph3, ph2, ph1} <= 3'h7;
        gap(0, (1 << ps) * m);
        chk(pin[5:0], 6'h15);
        {ph3, ph2, ph1} <= 3'h0;
        gap(1, (1 << ps) * m);
    endtask
    task automatic short_pulse();
        logic seen;
        seen = 1'b0;
        apb(1'b1, IDX_DEAD_BAND_CONTROL, 16'h08F8);
        repeat (70) @(posedge clk);
        ph1 <= 1'b1;
        repeat (10) @(posedge clk);
        ph1 <= 1'b0;
        repeat (80) begin
            @(posedge clk);
            seen = seen | pin[0];
        end
        chk(seen, 1'b0);
        chk(pin[1], 1'b1);
    endtask
    task automatic bypass_and_compare();
        logic [1:0] code [4] = '{CMP_RESET, CMP_SET, CMP_HOLD, CMP_TOGGLE};
        logic expv [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
        apb(1'b1, IDX_DEAD_BAND_CONTROL, 16'h0300);
        ph1 <= 1'b1;
        repeat (4) @(posedge clk);
        chk(pin[1:0], 2'h3);
        apb(1'b1, IDX_COMPARE_CONTROL, 16'h0301);
        // enable on unit 1 in compare mode must not open a gap
        apb(1'b1, IDX_DEAD_BAND_CONTROL, 16'h0320);
        apb(1'b0, IDX_STATUS, 16'h0000);
        chk(rd[14:9], 6'h09);
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, IDX_FULL_ACTION, {4'h0, 10'h2AA, code[k]});
            match <= 3'h1;
            @(posedge clk);
            match <= 3'h0;
            repeat (3) @(posedge clk);
            chk(pin[0], expv[k]);
        end
        ph1 <= 1'b0;
    endtask
    task automatic simple_codes();
        logic expv [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
        simple <= 3'h1;
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, IDX_SIMPLE_ACTION, {14'h0000, 2'(k)});
            repeat (3) @(posedge clk);
            chk(pin[6], expv[k]);
        end
        chk(pinOe_b[8:6], 3'h0);
    endtask
    task automatic protect_and_oe();
        apb(1'b1, IDX_COMPARE_CONTROL, 16'h0308);
        repeat (2) @(posedge clk);
        chk(pinOe_b, 9'h000);
        protect_b <= 1'b0;
        repeat (3) @(posedge clk);
        chk(pinOe_b, 9'h1FF);
        chk(gateOn, 6'h00);
        apb(1'b0, IDX_STATUS, 16'h0000);
        chk(rd[15], 1'b1);
        protect_b <= 1'b1;
        apb(1'b1, IDX_COMPARE_CONTROL, 16'h0108);
        repeat (2) @(posedge clk);
        chk(pinOe_b, 9'h03F);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        regs();
        for (int ps = 0; ps < 4; ps++) db_timing(8'h03, 2'(ps));
        db_timing(8'h00, 2'h0);
        short_pulse();
        chk(shoots, 0);
        bypass_and_compare();
        simple_codes();
        protect_and_oe();
        tally_and_finish();
    end
endmodule // test_pdb_output_logic
